/* File: logic/ssrc_pkg.sv */
// Constants, register map and field layout of the serial port control block
package ssrc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_RXBUF = 8'h0C;
    localparam logic [7:0] OFS_TXBUF = 8'h10;
    localparam logic [7:0] OFS_INT_STAT = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h01;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_INT = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Control register 0 fields
    localparam int C0_MSB_FIRST = 5;
    localparam int C0_CHAR7 = 4;
    localparam int C0_MASTER = 3;
    localparam int C0_MODE_HI = 2;
    localparam int C0_MODE_LO = 1;
    localparam logic [1:0] MODE_3WIRE = 2'h0;
    localparam logic [1:0] MODE_STE_HIGH = 2'h1;

    // Control register 1 fields
    localparam int C1_SSEL_HI = 7;
    localparam int C1_SSEL_LO = 6;
    localparam int C1_SWRST = 0;

    // Status register fields
    localparam int ST_LOOPBACK = 7;
    localparam int ST_CONFLICT = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_BUSY = 0;

    // Interrupt status and mask fields
    localparam int IRQ_RX = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_CONFLICT = 2;
    localparam int IRQ_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Character lengths and AHB codes
    localparam logic [2:0] LEN8_LAST = 3'h7;
    localparam logic [2:0] LEN7_LAST = 3'h6;
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic {SSRC_IDLE, SSRC_SHIFT} ssrc_state_t;

endpackage : ssrc_pkg

/* File: logic/ssrc_rx_if.sv */
// Link between the port control logic and its receive buffer store
`timescale 1ns/10ps
interface ssrc_rx_if;
    logic load;
    logic [7:0] shifted;
    logic char7;
    logic msb_first;
    logic rd;
    logic clr;
    logic [7:0] data;
    logic unread;

    modport user
    (
        output load, shifted, char7, msb_first, rd, clr,
        input data, unread
    );
    modport store
    (
        input load, shifted, char7, msb_first, rd, clr,
        output data, unread
    );
endinterface : ssrc_rx_if

/* File: logic/ssrc_rxbuf.sv */
// Receive buffer store with alignment and unread tracking
`timescale 1ns/10ps
module ssrc_rxbuf
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    ssrc_rx_if.store rx
);

    logic [7:0] data_ff;
    logic unread_ff;

    // Right-align short characters, top bit forced low
    function automatic logic [7:0] align(input logic [7:0] sh, input logic c7,
                                         input logic msb);
        logic [7:0] r;
        r = sh;
        if (c7 && msb)
        begin
            r = {1'b0, sh[6:0]};
        end
        else if (c7)
        begin
            r = {1'b0, sh[7:1]};
        end
        return r;
    endfunction : align

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_ff <= ssrc_pkg::RST_BYTE;
        end
        else if (ce && rx.load)
        begin
            data_ff <= align(rx.shifted, rx.char7, rx.msb_first);
        end
    end

    // New character wins over a read in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            unread_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (rx.load)
            begin
                unread_ff <= 1'b1;
            end
            else if (rx.rd || rx.clr)
            begin
                unread_ff <= 1'b0;
            end
        end
    end

    assign rx.data = data_ff;
    assign rx.unread = unread_ff;

endmodule : ssrc_rxbuf

/* File: logic/ssrc_top.sv */
// Serial port control, status and receive logic with AHB-Lite registers
// Function
// - Loopback bit set feeds transmitter output straight into the receiver.
// - Bus conflict as 4-wire master sets the framing error flag.
// - Framing error flag set in 3-wire master or any slave mode only by writing the status register.
// - Character loaded while previous still unread sets the overrun flag.
// - Reading the receive buffer clears overrun; software should not clear it.
// - Receive buffer holds last complete received character, eight bits.
// - Receive buffer read clears error bits and the receive pending flag.
// - Seven-bit characters are right-aligned with the top bit zero.
`timescale 1ns/10ps
module ssrc_top
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic ste_pin,
    output logic sdo,
    output logic sdo_oe,
    output logic [1:0] clk_src_sel,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic loop_ff;
    logic conflict_ff;
    logic overrun_ff;
    logic [7:0] txbuf_ff;
    logic [2:0] int_stat_ff;
    logic [2:0] int_mask_ff;
    logic irq_ff;
    logic hready_ff;
    logic [31:0] hrdata_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [2:0] sclk_sync_ff;
    logic [1:0] sdi_sync_ff;
    logic [1:0] ste_sync_ff;
    logic conf_seen_ff;
    ssrc_pkg::ssrc_state_t state_ff;
    logic [2:0] cnt_ff;
    logic [7:0] rx_sh_ff;
    logic [7:0] tx_sh_ff;
    logic sdo_ff;
    logic sdo_oe_ff;
    logic load_ff;

    logic acc;
    logic [7:0] acc_addr;
    logic rd_rxbuf;
    logic rd_int;
    logic swrst;
    logic char7;
    logic msb_first;
    logic master;
    logic four_wire;
    logic ste_act;
    logic link_on;
    logic rise;
    logic fall;
    logic rx_bit;
    logic [2:0] last;
    logic char_done;
    logic conflict_now;
    logic conflict_evt;
    logic busy;
    logic [7:0] nxt_rx_sh;
    logic [7:0] stat_rd;
    logic [31:0] nxt_hrdata;

    ssrc_rx_if rx_if ();

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign swrst = ctrl1_ff[ssrc_pkg::C1_SWRST];
    assign char7 = ctrl0_ff[ssrc_pkg::C0_CHAR7];
    assign msb_first = ctrl0_ff[ssrc_pkg::C0_MSB_FIRST];
    assign master = ctrl0_ff[ssrc_pkg::C0_MASTER];
    assign four_wire = ctrl0_ff[ssrc_pkg::C0_MODE_HI:ssrc_pkg::C0_MODE_LO]
                       != ssrc_pkg::MODE_3WIRE;
    assign ste_act = (ctrl0_ff[ssrc_pkg::C0_MODE_HI:ssrc_pkg::C0_MODE_LO]
                      == ssrc_pkg::MODE_STE_HIGH) ? ste_sync_ff[1] : ~ste_sync_ff[1];
    // Slave in 4-wire mode only listens while selected
    assign link_on = ~swrst && (master || !four_wire || ste_act);
    assign last = char7 ? ssrc_pkg::LEN7_LAST : ssrc_pkg::LEN8_LAST;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link clock edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sclk_sync_ff <= 3'h0;
            sdi_sync_ff <= 2'h0;
            ste_sync_ff <= 2'h3;
        end
        else if (ce)
        begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], sclk_pin};
            sdi_sync_ff <= {sdi_sync_ff[0], sdi_pin};
            ste_sync_ff <= {ste_sync_ff[0], ste_pin};
        end
    end

    assign rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    assign fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
    assign rx_bit = loop_ff ? sdo_ff : sdi_sync_ff[1];
    assign char_done = link_on && rise && (cnt_ff == last);
    assign nxt_rx_sh = msb_first ? {rx_sh_ff[6:0], rx_bit} : {rx_bit, rx_sh_ff[7:1]};

    ////////////////////////////////////////////////////////////////////////////
    // Shift engine
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= ssrc_pkg::SSRC_IDLE;
            cnt_ff <= ssrc_pkg::CNT_ZERO;
            rx_sh_ff <= ssrc_pkg::RST_BYTE;
            load_ff <= 1'b0;
        end
        else if (ce)
        begin
            load_ff <= char_done;
            if (!link_on)
            begin
                state_ff <= ssrc_pkg::SSRC_IDLE;
                cnt_ff <= ssrc_pkg::CNT_ZERO;
            end
            else if (rise)
            begin
                rx_sh_ff <= nxt_rx_sh;
                case (state_ff)
                    ssrc_pkg::SSRC_IDLE:
                    begin
                        state_ff <= ssrc_pkg::SSRC_SHIFT;
                        cnt_ff <= 3'h1;
                    end
                    ssrc_pkg::SSRC_SHIFT:
                    begin
                        if (cnt_ff == last)
                        begin
                            state_ff <= ssrc_pkg::SSRC_IDLE;
                            cnt_ff <= ssrc_pkg::CNT_ZERO;
                        end
                        else
                        begin
                            cnt_ff <= cnt_ff + 3'h1;
                        end
                    end
                    default:
                    begin
                        state_ff <= ssrc_pkg::SSRC_IDLE;
                        cnt_ff <= ssrc_pkg::CNT_ZERO;
                    end
                endcase
            end
        end
    end

    // Transmit shifter reloads between characters, shifts on falling edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_sh_ff <= ssrc_pkg::RST_BYTE;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (!link_on || (state_ff == ssrc_pkg::SSRC_IDLE && !rise))
            begin
                tx_sh_ff <= txbuf_ff;
            end
            else if (fall)
            begin
                tx_sh_ff <= msb_first ? {tx_sh_ff[6:0], 1'b0} : {1'b0, tx_sh_ff[7:1]};
            end
            sdo_ff <= msb_first ? (char7 ? tx_sh_ff[6] : tx_sh_ff[7]) : tx_sh_ff[0];
            sdo_oe_ff <= link_on && !loop_ff;
        end
    end

    assign busy = (state_ff == ssrc_pkg::SSRC_SHIFT) || load_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer
    assign rx_if.load = load_ff;
    assign rx_if.shifted = rx_sh_ff;
    assign rx_if.char7 = char7;
    assign rx_if.msb_first = msb_first;
    assign rx_if.rd = rd_rxbuf;
    assign rx_if.clr = swrst;

    ssrc_rxbuf u_rxbuf
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .rx(rx_if.store)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus conflict detection, 4-wire master only
    assign conflict_now = master && four_wire && ste_act && !swrst;
    assign conflict_evt = conflict_now && !conf_seen_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            conf_seen_ff <= 1'b0;
        end
        else if (ce)
        begin
            conf_seen_ff <= conflict_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    assign acc = hsel && hready && (htrans == ssrc_pkg::HTRANS_NONSEQ
                                    || htrans == ssrc_pkg::HTRANS_SEQ);
    assign acc_addr = {haddr[7:2], 2'h0};
    assign rd_rxbuf = ce && acc && !hwrite && acc_addr == ssrc_pkg::OFS_RXBUF;
    assign rd_int = ce && acc && !hwrite && acc_addr == ssrc_pkg::OFS_INT_STAT;

    always_comb
    begin
        stat_rd = 8'h00;
        stat_rd[ssrc_pkg::ST_LOOPBACK] = loop_ff;
        stat_rd[ssrc_pkg::ST_CONFLICT] = conflict_ff;
        stat_rd[ssrc_pkg::ST_OVERRUN] = overrun_ff;
        stat_rd[ssrc_pkg::ST_BUSY] = busy;
        case (acc_addr)
            ssrc_pkg::OFS_CTRL0: nxt_hrdata = {24'h000000, ctrl0_ff};
            ssrc_pkg::OFS_CTRL1: nxt_hrdata = {24'h000000, ctrl1_ff};
            ssrc_pkg::OFS_STAT: nxt_hrdata = {24'h000000, stat_rd};
            ssrc_pkg::OFS_RXBUF: nxt_hrdata = {24'h000000, rx_if.data};
            ssrc_pkg::OFS_TXBUF: nxt_hrdata = {24'h000000, txbuf_ff};
            ssrc_pkg::OFS_INT_STAT: nxt_hrdata = {29'h00000000, int_stat_ff};
            ssrc_pkg::OFS_INT_MASK: nxt_hrdata = {29'h00000000, int_mask_ff};
            default: nxt_hrdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hready_ff <= 1'b1;
            hrdata_ff <= 32'h00000000;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end
        else if (ce)
        begin
            wr_pend_ff <= acc && hwrite;
            if (acc)
            begin
                wr_addr_ff <= acc_addr;
            end
            if (acc && !hwrite)
            begin
                hrdata_ff <= nxt_hrdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl0_ff <= ssrc_pkg::RST_CTRL0;
            ctrl1_ff <= ssrc_pkg::RST_CTRL1;
            txbuf_ff <= ssrc_pkg::RST_BYTE;
            int_mask_ff <= ssrc_pkg::RST_INT;
            loop_ff <= 1'b0;
        end
        else if (ce && wr_pend_ff)
        begin
            case (wr_addr_ff)
                ssrc_pkg::OFS_CTRL0: ctrl0_ff <= hwdata[7:0];
                ssrc_pkg::OFS_CTRL1: ctrl1_ff <= hwdata[7:0] & 8'hC1;
                ssrc_pkg::OFS_TXBUF: txbuf_ff <= hwdata[7:0];
                ssrc_pkg::OFS_INT_MASK: int_mask_ff <= hwdata[2:0];
                ssrc_pkg::OFS_STAT: loop_ff <= hwdata[ssrc_pkg::ST_LOOPBACK];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error flags: set wins over any clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            conflict_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (conflict_now)
            begin
                conflict_ff <= 1'b1;
            end
            else if (rd_rxbuf || swrst)
            begin
                conflict_ff <= 1'b0;
            end
            else if (wr_pend_ff && wr_addr_ff == ssrc_pkg::OFS_STAT)
            begin
                conflict_ff <= hwdata[ssrc_pkg::ST_CONFLICT];
            end
            if (load_ff && rx_if.unread)
            begin
                overrun_ff <= 1'b1;
            end
            else if (rd_rxbuf || swrst)
            begin
                overrun_ff <= 1'b0;
            end
            else if (wr_pend_ff && wr_addr_ff == ssrc_pkg::OFS_STAT)
            begin
                overrun_ff <= hwdata[ssrc_pkg::ST_OVERRUN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, read clears, set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            int_stat_ff <= ssrc_pkg::RST_INT;
            irq_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (load_ff)
            begin
                int_stat_ff[ssrc_pkg::IRQ_RX] <= 1'b1;
            end
            else if (rd_rxbuf || rd_int || swrst)
            begin
                int_stat_ff[ssrc_pkg::IRQ_RX] <= 1'b0;
            end
            if (load_ff && rx_if.unread)
            begin
                int_stat_ff[ssrc_pkg::IRQ_OVERRUN] <= 1'b1;
            end
            else if (rd_int || swrst)
            begin
                int_stat_ff[ssrc_pkg::IRQ_OVERRUN] <= 1'b0;
            end
            if (conflict_evt)
            begin
                int_stat_ff[ssrc_pkg::IRQ_CONFLICT] <= 1'b1;
            end
            else if (rd_int || swrst)
            begin
                int_stat_ff[ssrc_pkg::IRQ_CONFLICT] <= 1'b0;
            end
            irq_ff <= |(int_stat_ff & int_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout = hready_ff;
    assign hrdata = hrdata_ff;
    assign hresp = ssrc_pkg::HRESP_OKAY;
    assign sdo = sdo_ff;
    assign sdo_oe = sdo_oe_ff;
    assign clk_src_sel = ctrl1_ff[ssrc_pkg::C1_SSEL_HI:ssrc_pkg::C1_SSEL_LO];
    assign irq = irq_ff;

endmodule : ssrc_top

/* File: verif/ssrc_checker.sv */
// Checker on the top ports of the serial port control block
`timescale 1ns/10ps
module ssrc_checker
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic sdo_oe,
    input wire logic [1:0] clk_src_sel,
    input wire logic irq
);
    logic take;
    logic dp_ff;
    logic dp_wr_ff;
    logic [7:0] dp_ofs_ff;
    logic [7:0] ctrl0_ff;
    logic [2:0] mask_ff;
    logic loop_ff;

    assign take = hsel && hready && htrans[1] && ce;

    // Data phase tracking
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_ff <= 1'b0;
            dp_wr_ff <= 1'b0;
            dp_ofs_ff <= 8'h00;
        end
        else
        begin
            dp_ff <= take;
            dp_wr_ff <= hwrite;
            dp_ofs_ff <= haddr[7:0];
        end
    end

    // Shadows of written fields
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl0_ff <= 8'h00;
            mask_ff <= 3'h0;
            loop_ff <= 1'b0;
        end
        else if (dp_ff && dp_wr_ff)
        begin
            if (dp_ofs_ff == ssrc_pkg::OFS_CTRL0)
                ctrl0_ff <= hwdata[7:0];
            if (dp_ofs_ff == ssrc_pkg::OFS_INT_MASK)
                mask_ff <= hwdata[2:0];
            if (dp_ofs_ff == ssrc_pkg::OFS_STAT)
                loop_ff <= hwdata[7];
        end
    end

    ////////////////////////////////////////
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_rd(logic [7:0] ofs);
        take && !hwrite && haddr[7:0] == ofs;
    endsequence

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_ctrl1_unused: assert property (s_rd(ssrc_pkg::OFS_CTRL1) |=>
        hrdata[31:8] == 24'h000000 && hrdata[5:1] == 5'h00)
        else $error("control one unused bits not zero");
    chk_rx_width: assert property (s_rd(ssrc_pkg::OFS_RXBUF) |=>
        hrdata[31:8] == 24'h000000 && !(hrdata[7] && $past(ctrl0_ff[4])))
        else $error("receive buffer wider than eight bits");
    chk_no_conflict: assert property (s_rd(ssrc_pkg::OFS_STAT) ##0
        (!ctrl0_ff[3] || ctrl0_ff[2:1] == ssrc_pkg::MODE_3WIRE) |=> !hrdata[6])
        else $error("conflict flag set outside four wire master");
    chk_loop_quiet: assert property (loop_ff && $past(loop_ff, 3) |-> !sdo_oe)
        else $error("data output driven during loopback");
    chk_irq_masked: assert property (mask_ff == 3'h0 && $past(mask_ff, 3) == 3'h0 |-> !irq)
        else $error("interrupt raised while fully masked");
    chk_clk_src: assert property (dp_ff && dp_wr_ff &&
        dp_ofs_ff == ssrc_pkg::OFS_CTRL1 |=> clk_src_sel == $past(hwdata[7:6]))
        else $error("clock source field not updated by write");
    chk_rx_clears: assert property (s_rd(ssrc_pkg::OFS_RXBUF) ##3
        s_rd(ssrc_pkg::OFS_STAT) |=> hrdata[6:5] == 2'h0)
        else $error("error flags survive receive buffer read");
    chk_rx_pend_clr: assert property (s_rd(ssrc_pkg::OFS_RXBUF) ##3
        s_rd(ssrc_pkg::OFS_INT_STAT) |=> !hrdata[0])
        else $error("receive pending survives buffer read");
    chk_irq_clears: assert property (s_rd(ssrc_pkg::OFS_INT_STAT) |-> ##[2:3] !irq)
        else $error("interrupt stays up after status read");
endmodule : ssrc_checker

bind ssrc_top ssrc_checker u_ssrc_checker
(
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .sdo_oe, .clk_src_sel, .irq
);

/* File: verif/ssrc_link_model.sv */
// Far-side serial master driving link clock, data and select
`timescale 1ns/10ps
module ssrc_link_model
(
    output logic sclk_pin,
    output logic sdi_pin,
    output logic ste_pin
);
    initial
    begin
        sclk_pin = 1'b0;
        sdi_pin = 1'b0;
        ste_pin = 1'b0;
    end

    task automatic set_ste(input logic lvl);
        ste_pin <= lvl;
    endtask : set_ste

    // Data set while clock low; clock stands low between frames
    task automatic send_char(input logic [7:0] ch, input int nbits, input logic msb,
        input logic act, input int half);
        #13;
        ste_pin = act;
        #(half);
        for (int i = 0; i < nbits; i++)
        begin
            sdi_pin = msb ? ch[nbits - 1 - i] : ch[i];
            #(half);
            sclk_pin = 1'b1;
            #(half);
            sclk_pin = 1'b0;
        end
        #(half);
        ste_pin = !act;
        // Released line shows no stale level
        sdi_pin = !sdi_pin;
    endtask : send_char
endmodule : ssrc_link_model

/* File: verif/ssrc_top_test.sv */
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module ssrc_top_test;
    logic hclk;
    logic hresetn;
    logic ce;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic sclk_pin;
    logic sdi_pin;
    logic ste_pin;
    logic sdo;
    logic sdo_oe;
    logic [1:0] clk_src_sel;
    logic irq;
    logic [31:0] rd_data;
    int error_cnt;
    int n_checks;
    int cyc;

    assign hready = hreadyout;

    ssrc_top u_ssrc_top
    (
        .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .sclk_pin, .sdi_pin, .ste_pin, .sdo, .sdo_oe,
        .clk_src_sel, .irq
    );

    ssrc_link_model u_ssrc_link_model (.sclk_pin, .sdi_pin, .ste_pin);

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    ////////////////////////////////////////
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, ofs};
        htrans <= ssrc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rd_data = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        bus(1'b1, ofs, d);
    endtask : wr

    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        bus(1'b0, ofs, 8'h00);
        `CHK($sformatf("reg %0h", ofs), {24'h000000, exp}, rd_data)
    endtask : rd

    task automatic send(input logic [7:0] ch, input int n, input logic msb);
        u_ssrc_link_model.send_char(ch, n, msb, 1'b1, 160);
        repeat (4) @(posedge hclk);
    endtask : send

    task automatic test_done;
        $display("TB: checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    ////////////////////////////////////////
    initial
    begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ssrc_pkg::OFS_CTRL1, 8'h01);
        rd(ssrc_pkg::OFS_STAT, 8'h00);
        rd(ssrc_pkg::OFS_RXBUF, 8'h00);
        `CHK("clk_src_sel", 2'h0, clk_src_sel)
        wr(ssrc_pkg::OFS_INT_MASK, 8'h07);
        wr(ssrc_pkg::OFS_CTRL0, 8'h22);
        send(8'hA5, 8, 1'b1);
        rd(ssrc_pkg::OFS_INT_STAT, 8'h00);
        rd(ssrc_pkg::OFS_RXBUF, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(ssrc_pkg::OFS_CTRL1, {s[1:0], 6'h3E});
            rd(ssrc_pkg::OFS_CTRL1, {s[1:0], 6'h00});
            `CHK("clk_src_sel", s[1:0], clk_src_sel)
        end
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h00);
        $display("TB: test registers done");
        fork
            send(8'hA5, 8, 1'b1);
            begin
                repeat (30) @(posedge hclk);
                rd(ssrc_pkg::OFS_STAT, 8'h01);
            end
        join
        `CHK("irq", 1'b1, irq)
        rd(ssrc_pkg::OFS_RXBUF, 8'hA5);
        rd(ssrc_pkg::OFS_INT_STAT, 8'h00);
        `CHK("irq", 1'b0, irq)
        wr(ssrc_pkg::OFS_CTRL0, 8'h02);
        send(8'h3C, 8, 1'b0);
        rd(ssrc_pkg::OFS_RXBUF, 8'h3C);
        $display("TB: test receive done");
        wr(ssrc_pkg::OFS_INT_MASK, 8'h00);
        send(8'h11, 8, 1'b0);
        send(8'hE7, 8, 1'b0);
        `CHK("irq", 1'b0, irq)
        rd(ssrc_pkg::OFS_STAT, 8'h20);
        rd(ssrc_pkg::OFS_RXBUF, 8'hE7);
        rd(ssrc_pkg::OFS_STAT, 8'h00);
        rd(ssrc_pkg::OFS_INT_STAT, 8'h02);
        rd(ssrc_pkg::OFS_INT_STAT, 8'h00);
        wr(ssrc_pkg::OFS_INT_MASK, 8'h07);
        wr(ssrc_pkg::OFS_CTRL0, 8'h32);
        send(8'h6B, 7, 1'b1);
        rd(ssrc_pkg::OFS_RXBUF, 8'h6B);
        wr(ssrc_pkg::OFS_CTRL0, 8'h12);
        send(8'hD5, 7, 1'b0);
        rd(ssrc_pkg::OFS_RXBUF, 8'h55);
        $display("TB: test overrun and length done");
        wr(ssrc_pkg::OFS_CTRL0, 8'h28);
        repeat (2) @(posedge hclk);
        `CHK("sdo_oe", 1'b1, sdo_oe)
        wr(ssrc_pkg::OFS_STAT, 8'h80);
        wr(ssrc_pkg::OFS_TXBUF, 8'h5A);
        `CHK("sdo_oe", 1'b0, sdo_oe)
        send(8'hA5, 8, 1'b1);
        rd(ssrc_pkg::OFS_RXBUF, 8'h5A);
        rd(ssrc_pkg::OFS_STAT, 8'h80);
        wr(ssrc_pkg::OFS_STAT, 8'h00);
        wr(ssrc_pkg::OFS_TXBUF, 8'hC3);
        repeat (3) @(posedge hclk);
        `CHK("sdo_oe", 1'b1, sdo_oe)
        `CHK("sdo", 1'b1, sdo)
        u_ssrc_link_model.set_ste(1'b1);
        wr(ssrc_pkg::OFS_CTRL0, 8'h0A);
        repeat (4) @(posedge hclk);
        rd(ssrc_pkg::OFS_STAT, 8'h40);
        rd(ssrc_pkg::OFS_INT_STAT, 8'h04);
        u_ssrc_link_model.set_ste(1'b0);
        repeat (4) @(posedge hclk);
        rd(ssrc_pkg::OFS_RXBUF, 8'h5A);
        rd(ssrc_pkg::OFS_STAT, 8'h00);
        $display("TB: test loopback and conflict done");
        test_done();
    end
endmodule : ssrc_top_test
